// >>> rtl/supply_fault_pkg.sv
// Package for the motor supply undervoltage fault block
package supply_fault_pkg;

  localparam logic [7:0] ctrl_offset   = 8'h00;
  localparam logic [7:0] status_offset = 8'h04;
  localparam logic [7:0] irq_offset    = 8'h08;
  localparam logic [7:0] mask_offset   = 8'h0c;

  localparam int ctrl_clear_bit  = 0;
  localparam int ctrl_serial_bit = 1;

  localparam int st_fault_bit    = 0;
  localparam int st_low_bit      = 1;
  localparam int st_below_fall   = 2;
  localparam int st_above_rise   = 3;
  localparam int st_core_ok      = 4;

  localparam int ev_fall_bit     = 0;
  localparam int ev_rise_bit     = 1;

  localparam logic [1:0] ctrl_reset_value = 2'h2;
  localparam logic [1:0] mask_reset_value = 2'h0;

  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  typedef enum logic [1:0] {
    core_off,
    supply_low,
    supply_good
  } supply_state_t;

  typedef struct packed {
    logic [2:0] fall_sync1;
    logic [2:0] fall_sync2;
    logic       sleep_sync1;
    logic       sleep_sync2;
    logic       sleep_prev;
    supply_state_t state;
    logic       low_flag;
    logic       summary;
    logic       serial_mode;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic       aw_got;
    logic [7:0] aw_addr;
    logic       w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fault_state_t;

endpackage : supply_fault_pkg

// >>> rtl/motor_supply_undervoltage_fault.sv
// Motor supply undervoltage fault logic with an AXI4-Lite register slave
// Behaviour
// - Below falling threshold: outputs high impedance, charge pump off, fault pin low.
// - Above rising threshold again: driver and charge pump resume with no software.
// - Serial mode, fall from good supply, core alive: summary and low flag set, pin low.
// - Recovery above rising threshold: fault pin released, summary bit back to zero.
// - Low flag stays set until clear-faults write or sleep reset pulse.
// - Below core reset level: core off, bits zero, fault pin high.
// - Power-up past core reset: low flag zero, summary one in serial mode, fault pin low.
// - Then above rising threshold: summary zero, low flag zero, pin released.
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module motor_supply_undervoltage_fault
  import supply_fault_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        below_fall_cmp,
  input  wire logic        above_rise_cmp,
  input  wire logic        above_core_cmp,
  input  wire logic        sleep_pin_n,
  output logic             bridge_enable,
  output logic             charge_pump_enable,
  output logic             fault_pin_n_oe,
  output logic             fault_pin_n_out,
  output logic             irq,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp
);

  fault_state_t cur_ff;
  fault_state_t nxt_cur;

  logic below_fall;
  logic above_rise;
  logic core_ok;
  logic pin_low;
  logic do_write;
  logic do_read;
  logic clear_req;
  logic sleep_pulse;

  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == ctrl_offset) || (a == status_offset) ||
                  (a == irq_offset) || (a == mask_offset);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised comparators and the fault state
  assign below_fall = cur_ff.fall_sync2[0];
  assign above_rise = cur_ff.fall_sync2[1];
  assign core_ok    = cur_ff.fall_sync2[2];
  assign sleep_pulse = cur_ff.sleep_prev & ~cur_ff.sleep_sync2;
  assign do_write = cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid;
  assign do_read  = s_axi_arvalid && !cur_ff.rvalid;
  assign clear_req = (do_write && cur_ff.aw_addr == ctrl_offset && cur_ff.w_strb[0] &&
                      cur_ff.w_data[ctrl_clear_bit]) || sleep_pulse;

  // Pin low while the core lives and the supply has not risen above rising threshold since power-up or a fall
  assign pin_low = cur_ff.state == supply_low;

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.fall_sync1  = {above_core_cmp, above_rise_cmp, below_fall_cmp};
    nxt_cur.fall_sync2  = cur_ff.fall_sync1;
    nxt_cur.sleep_sync1 = sleep_pin_n;
    nxt_cur.sleep_sync2 = cur_ff.sleep_sync1;
    nxt_cur.sleep_prev  = cur_ff.sleep_sync2;

    unique case (cur_ff.state)
      core_off: begin
        nxt_cur.low_flag = 1'b0;
        if (core_ok) begin
          nxt_cur.state = supply_low;
        end
      end
      supply_low: begin
        if (!core_ok) begin
          nxt_cur.state = core_off;
        end else if (above_rise && !below_fall) begin
          nxt_cur.state = supply_good;
        end
      end
      supply_good: begin
        if (!core_ok) begin
          nxt_cur.state = core_off;
        end else if (below_fall) begin
          nxt_cur.state = supply_low;
        end
      end
    endcase

    // Set wins over clear on the latched low flag
    if (nxt_cur.state == core_off) begin
      nxt_cur.low_flag = 1'b0;
    end else if (cur_ff.state == supply_good && below_fall && core_ok &&
                 cur_ff.serial_mode) begin
      nxt_cur.low_flag = 1'b1;
    end else if (clear_req) begin
      nxt_cur.low_flag = 1'b0;
    end
    nxt_cur.summary = cur_ff.serial_mode && (nxt_cur.state == supply_low);

    // Interrupt events: entry to low supply and its exit to good supply
    if (do_write && cur_ff.aw_addr == irq_offset && cur_ff.w_strb[0]) begin
      nxt_cur.irq_status = cur_ff.irq_status & ~cur_ff.w_data[1:0];
    end
    if (cur_ff.state != supply_low && nxt_cur.state == supply_low) begin
      nxt_cur.irq_status[ev_fall_bit] = 1'b1;
    end
    if (cur_ff.state == supply_low && nxt_cur.state == supply_good) begin
      nxt_cur.irq_status[ev_rise_bit] = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write path
    if (s_axi_awvalid && !cur_ff.aw_got) begin
      nxt_cur.aw_got  = 1'b1;
      nxt_cur.aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !cur_ff.w_got) begin
      nxt_cur.w_got  = 1'b1;
      nxt_cur.w_data = s_axi_wdata;
      nxt_cur.w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_cur.aw_got = 1'b0;
      nxt_cur.w_got  = 1'b0;
      nxt_cur.bvalid = 1'b1;
      nxt_cur.bresp  = addr_mapped(cur_ff.aw_addr) ? resp_okay : resp_slverr;
      if (cur_ff.aw_addr == ctrl_offset && cur_ff.w_strb[0]) begin
        nxt_cur.serial_mode = cur_ff.w_data[ctrl_serial_bit];
      end
      if (cur_ff.aw_addr == mask_offset && cur_ff.w_strb[0]) begin
        nxt_cur.irq_mask = cur_ff.w_data[1:0];
      end
    end
    if (cur_ff.bvalid && s_axi_bready) begin
      nxt_cur.bvalid = 1'b0;
    end

    // AXI4-Lite read path
    if (do_read) begin
      nxt_cur.rvalid = 1'b1;
      nxt_cur.rresp  = addr_mapped(s_axi_araddr) ? resp_okay : resp_slverr;
      nxt_cur.rdata  = 32'h0;
      unique case ({s_axi_araddr[7:2], 2'b00})
        ctrl_offset: nxt_cur.rdata[1:0] = {cur_ff.serial_mode, 1'b0};
        status_offset: begin
          nxt_cur.rdata[st_fault_bit]  = cur_ff.summary;
          nxt_cur.rdata[st_low_bit]    = cur_ff.low_flag;
          nxt_cur.rdata[st_below_fall] = below_fall;
          nxt_cur.rdata[st_above_rise] = above_rise;
          nxt_cur.rdata[st_core_ok]    = core_ok;
        end
        irq_offset:  nxt_cur.rdata[1:0] = cur_ff.irq_status;
        mask_offset: nxt_cur.rdata[1:0] = cur_ff.irq_mask;
        default:     nxt_cur.rdata = 32'h0;
      endcase
    end else if (cur_ff.rvalid && s_axi_rready) begin
      nxt_cur.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ff <= '{fall_sync1: 3'h0, fall_sync2: 3'h0, sleep_sync1: 1'b1,
                  sleep_sync2: 1'b1, sleep_prev: 1'b1, state: core_off,
                  low_flag: 1'b0, summary: 1'b0, serial_mode: ctrl_reset_value[1],
                  irq_status: 2'h0, irq_mask: mask_reset_value, aw_got: 1'b0,
                  aw_addr: 8'h0, w_got: 1'b0, w_data: 32'h0, w_strb: 4'h0,
                  bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0, rdata: 32'h0,
                  rresp: 2'h0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bridge_enable      = cur_ff.state == supply_good;
  assign charge_pump_enable = cur_ff.state == supply_good;
  assign fault_pin_n_out    = 1'b0;
  assign fault_pin_n_oe     = pin_low;
  assign irq                = |(cur_ff.irq_status & cur_ff.irq_mask);
  assign s_axi_awready = !cur_ff.aw_got;
  assign s_axi_wready  = !cur_ff.w_got;
  assign s_axi_bvalid  = cur_ff.bvalid;
  assign s_axi_bresp   = cur_ff.bresp;
  assign s_axi_arready = !cur_ff.rvalid;
  assign s_axi_rvalid  = cur_ff.rvalid;
  assign s_axi_rdata   = cur_ff.rdata;
  assign s_axi_rresp   = cur_ff.rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_LOW_DISABLES: assert property (@(posedge clk) disable iff (!rst_n)
    (below_fall && core_ok)
      |=> (!bridge_enable && !charge_pump_enable && fault_pin_n_oe))
    else $error("Low supply left outputs enabled");
  AST_AUTO_RESUME: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == supply_low && core_ok && above_rise && !below_fall)
      |=> (bridge_enable && charge_pump_enable))
    else $error("Driver did not resume after recovery");
  AST_LOW_SETS_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == supply_good && below_fall && core_ok && cur_ff.serial_mode)
      |=> (cur_ff.low_flag && cur_ff.summary && fault_pin_n_oe))
    else $error("Low supply did not set flags");
  AST_RECOVER_SUMMARY: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(bridge_enable) |-> (!cur_ff.summary && !fault_pin_n_oe))
    else $error("Summary still set after recovery");
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.low_flag && !clear_req && core_ok) |=> cur_ff.low_flag)
    else $error("Low flag dropped without clear");
  AST_CORE_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == core_off)
      |-> (!cur_ff.low_flag && !cur_ff.summary && !fault_pin_n_oe))
    else $error("Core off state shows fault");
  AST_POWER_UP: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == core_off && core_ok)
      |=> (cur_ff.state == supply_low && !cur_ff.low_flag && fault_pin_n_oe))
    else $error("Power-up entry wrong");
  AST_POWER_UP_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == supply_low && !cur_ff.low_flag && core_ok && above_rise && !below_fall)
      |=> (!cur_ff.low_flag && !cur_ff.summary && !fault_pin_n_oe))
    else $error("Power-up completion wrong");
  AST_SYNC_DEPTH: assert property (@(posedge clk) disable iff (!rst_n)
    ##2 (cur_ff.fall_sync2 == $past({above_core_cmp, above_rise_cmp, below_fall_cmp}, 2)))
    else $error("Comparator synchroniser depth wrong");

  ////////////////////////////////////////////////////////////////////////////
  // Event, clear and recovery checks
  AST_FALL_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == supply_good && core_ok && below_fall)
      |=> cur_ff.irq_status[ev_fall_bit])
    else $error("Fall event not recorded");
  AST_RISE_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == supply_low && core_ok && above_rise && !below_fall)
      |=> cur_ff.irq_status[ev_rise_bit])
    else $error("Rise event not recorded");
  AST_NON_SERIAL_QUIET: assert property (@(posedge clk) disable iff (!rst_n)
    (!cur_ff.serial_mode && !cur_ff.low_flag)
      |=> (!cur_ff.summary && !cur_ff.low_flag))
    else $error("Fault bits set outside serial mode");
  AST_PIN_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == supply_low && core_ok && above_rise && !below_fall)
      |=> (!fault_pin_n_oe && !cur_ff.summary))
    else $error("Fault pin held after recovery");
  AST_RISE_KEEPS_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.low_flag && core_ok && above_rise && !below_fall && !clear_req)
      |=> cur_ff.low_flag)
    else $error("Low flag lost on recovery");
  AST_CLEAR_WORKS: assert property (@(posedge clk) disable iff (!rst_n)
    (clear_req && !below_fall)
      |=> !cur_ff.low_flag)
    else $error("Clear did not drop low flag");
  AST_SLEEP_CLEARS: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.sleep_prev && !cur_ff.sleep_sync2 && !below_fall)
      |=> !cur_ff.low_flag)
    else $error("Sleep pulse did not drop low flag");

  ////////////////////////////////////////////////////////////////////////////
  // Core loss and power-up checks
  AST_CORE_LOSS: assert property (@(posedge clk) disable iff (!rst_n)
    !core_ok
      |=> (cur_ff.state == core_off && !bridge_enable && !fault_pin_n_oe))
    else $error("Core loss did not shut down");
  AST_CORE_LOSS_BITS: assert property (@(posedge clk) disable iff (!rst_n)
    !core_ok
      |=> (!cur_ff.low_flag && !cur_ff.summary && !charge_pump_enable))
    else $error("Core loss left fault bits set");
  AST_POWER_UP_SUMMARY: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == core_off && core_ok && cur_ff.serial_mode)
      |=> (cur_ff.summary && !bridge_enable))
    else $error("Power-up did not set summary");
  AST_FLAG_ONLY_FROM_GOOD: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state != supply_good && !cur_ff.low_flag)
      |=> !cur_ff.low_flag)
    else $error("Low flag set outside a fall");
  AST_PIN_HIGH_WHEN_GOOD: assert property (@(posedge clk) disable iff (!rst_n)
    (cur_ff.state == supply_good && core_ok && !below_fall)
      |=> !fault_pin_n_oe)
    else $error("Fault pin low with good supply");
  AST_SLEEP_SYNC: assert property (@(posedge clk) disable iff (!rst_n)
    ##2 (cur_ff.sleep_sync2 == $past(sleep_pin_n, 2)))
    else $error("Sleep synchroniser depth wrong");

endmodule : motor_supply_undervoltage_fault
`default_nettype wire

// >>> verification/fault_host_model.sv
// Host side of the open-drain fault line with its external pull-up
`timescale 1ns/1ns
`default_nettype none
module fault_host_model (
  input  wire logic fault_pin_n_oe,
  input  wire logic fault_pin_n_out,
  output logic      fault_line
);
  // Released line floats up to the pull-up level
  assign fault_line = fault_pin_n_oe ? fault_pin_n_out : 1'b1;
endmodule // fault_host_model
`default_nettype wire

// >>> verification/testbench.sv
// Self-checking testbench for the motor supply undervoltage fault block
`timescale 1ns/1ns
`default_nettype none
module testbench
  import supply_fault_pkg::*;
;
  logic        clk, rst_n, below_fall_cmp, above_rise_cmp, above_core_cmp, sleep_pin_n;
  logic        bridge_enable, charge_pump_enable, fault_pin_n_oe, fault_pin_n_out, irq;
  logic        fault_line, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  int          num_errors, tests_run, cycles;

  motor_supply_undervoltage_fault u_motor_supply_undervoltage_fault (
    .clk(clk), .rst_n(rst_n), .below_fall_cmp(below_fall_cmp),
    .above_rise_cmp(above_rise_cmp), .above_core_cmp(above_core_cmp),
    .sleep_pin_n(sleep_pin_n), .bridge_enable(bridge_enable),
    .charge_pump_enable(charge_pump_enable), .fault_pin_n_oe(fault_pin_n_oe),
    .fault_pin_n_out(fault_pin_n_out), .irq(irq),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .s_axi_rdata(rdata), .s_axi_rresp(rresp));

  fault_host_model u_fault_host_model (
    .fault_pin_n_oe(fault_pin_n_oe), .fault_pin_n_out(fault_pin_n_out), .fault_line(fault_line));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // Write: address and data offered together, each dropped once taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= 4'hf;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    check("write response", {30'h0, bresp}, {30'h0, resp_okay});
  endtask

  task automatic axi_read(input logic [7:0] a);
    arvalid <= 1'b1; araddr <= a;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd = rdata;
    rsp = rresp;
  endtask

  // Comparators pass two sync stages and one state edge
  task automatic set_cmp(input logic core, input logic rise, input logic fall);
    above_core_cmp <= core; above_rise_cmp <= rise; below_fall_cmp <= fall;
    repeat (5) @(posedge clk);
  endtask

  task automatic expect_state(input logic en, input logic line, input logic sum, input logic flg);
    check("bridge enable", {31'h0, bridge_enable}, {31'h0, en});
    check("charge pump enable", {31'h0, charge_pump_enable}, {31'h0, en});
    check("fault line", {31'h0, fault_line}, {31'h0, line});
    axi_read(status_offset);
    check("status", rd, {27'h0, above_core_cmp, above_rise_cmp, below_fall_cmp, flg, sum});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_reset_regs();
    expect_state(1'b0, 1'b1, 1'b0, 1'b0);
    axi_read(ctrl_offset);
    check("ctrl reset", rd, {30'h0, ctrl_reset_value});
    axi_read(mask_offset);
    check("mask reset", rd, {30'h0, mask_reset_value});
    axi_read(8'h10);
    check("unmapped resp", {30'h0, rsp}, {30'h0, resp_slverr});
    check("unmapped data", rd, 32'h0);
  endtask

  task automatic test_power_up();
    set_cmp(1'b1, 1'b0, 1'b1);
    expect_state(1'b0, 1'b0, 1'b1, 1'b0);
    set_cmp(1'b1, 1'b1, 1'b0);
    expect_state(1'b1, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic test_fall_and_clear(input logic by_sleep);
    axi_write(mask_offset, 32'h1);
    axi_write(irq_offset, 32'h3);
    check("irq idle", {31'h0, irq}, 32'h0);
    set_cmp(1'b1, 1'b0, 1'b1);
    expect_state(1'b0, 1'b0, 1'b1, 1'b1);
    check("irq on fall", {31'h0, irq}, 32'h1);
    axi_write(irq_offset, 32'h3);
    check("irq cleared", {31'h0, irq}, 32'h0);
    set_cmp(1'b1, 1'b1, 1'b0);
    expect_state(1'b1, 1'b1, 1'b0, 1'b1);
    check("irq masked rise", {31'h0, irq}, 32'h0);
    axi_read(irq_offset);
    check("rise event", rd, 32'h2);
    if (by_sleep) begin
      sleep_pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      sleep_pin_n <= 1'b1;
      repeat (4) @(posedge clk);
    end else begin
      axi_write(ctrl_offset, 32'h3);
    end
    expect_state(1'b1, 1'b1, 1'b0, 1'b0);
    axi_read(ctrl_offset);
    check("ctrl clear self", rd, 32'h2);
  endtask

  task automatic test_non_serial();
    axi_write(ctrl_offset, 32'h0);
    axi_read(ctrl_offset);
    check("ctrl serial off", rd, 32'h0);
    set_cmp(1'b1, 1'b0, 1'b1);
    expect_state(1'b0, 1'b0, 1'b0, 1'b0);
    set_cmp(1'b1, 1'b1, 1'b0);
    expect_state(1'b1, 1'b1, 1'b0, 1'b0);
    axi_write(ctrl_offset, {30'h0, ctrl_reset_value});
  endtask

  task automatic test_core_loss();
    set_cmp(1'b1, 1'b0, 1'b1);
    set_cmp(1'b0, 1'b0, 1'b1);
    check("fault line core off", {31'h0, fault_line}, 32'h1);
    check("bridge core off", {31'h0, bridge_enable}, 32'h0);
    expect_state(1'b0, 1'b1, 1'b0, 1'b0);
    set_cmp(1'b1, 1'b0, 1'b1);
    expect_state(1'b0, 1'b0, 1'b1, 1'b0);
  endtask

  initial begin
    num_errors = 0; tests_run = 0; cycles = 0;
    rst_n = 1'b0; below_fall_cmp = 1'b0; above_rise_cmp = 1'b0; above_core_cmp = 1'b0;
    sleep_pin_n = 1'b1; awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_reset_regs();
    test_power_up();
    test_fall_and_clear(1'b0);
    test_fall_and_clear(1'b1);
    test_non_serial();
    test_core_loss();
    tally_and_finish();
  end
endmodule // testbench
`default_nettype wire
